// ### bench/msim_core_chk.sv
// checker on the simulation-mode core ports
// assumes one clock domain with async active-low reset
`timescale 1ns/1ps
`default_nettype none
module msim_core_chk
  import msim_pkg::*;
(
  input wire logic        i_core_clk, i_arst_n,
  input wire logic [15:0] i_fw_version, o_calc_load, o_calc_torque,
  input wire logic [15:0] o_load_factor,
  input wire logic [31:0] o_command_pos, o_motor_pos, o_overflow_rot,
  input wire logic [31:0] o_pos_deviation, o_speed_deviation,
  input wire logic        o_sim_active, o_busy, o_homing_refused,
  input wire logic        o_phys_excite, o_phys_brake_release,
  input wire logic        o_absolute_position_valid_output,
  input wire logic        o_preset_home_set_output, o_factory_home_set_output,
  input wire logic        o_sensor_alarm, o_sensor_home_write
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  dev_zero_a: assert property (o_sim_active |->
    o_pos_deviation == 0 && o_speed_deviation == 0) else $error("dev");
  motor_follow_a: assert property (
    (o_sim_active && $stable(o_command_pos))[*3] |->
    o_motor_pos == o_command_pos) else $error("motor pos");
  undef_mon_a: assert property (o_sim_active |->
    o_calc_load == UNDEF_VAL && o_calc_torque == UNDEF_VAL) else $error("ld");
  zero_mon_a: assert property (o_sim_active |->
    o_overflow_rot == 0 && o_load_factor == 0) else $error("ovf");
  no_drive_a: assert property (!o_phys_excite &&
    !o_phys_brake_release) else $error("drive");
  home_keep_a: assert property (!o_sensor_home_write)
    else $error("home write");
  home_flags_a: assert property (
    (o_sim_active && i_fw_version >= FW_VER_400)[*2] |->
    o_absolute_position_valid_output && !o_preset_home_set_output &&
    !o_factory_home_set_output) else $error("flags");
  alarm_off_a: assert property (o_sim_active |=> !o_sensor_alarm)
    else $error("alarm");
  refuse_fw_a: assert property (o_homing_refused |->
    i_fw_version < FW_VER_400 && !o_busy) else $error("refuse");
endmodule
bind msim_core msim_core_chk u_chk (.*);
`default_nettype wire

// ### bench/msim_master.sv
// master model: home request, then home sensor asserted on purpose
// assumes i_go is a one-cycle pulse on the core clock
`timescale 1ns/1ps
`default_nettype none
module msim_master (
  input  wire logic i_core_clk,
  input  wire logic i_go,
  output logic      o_home,
  output logic      o_home_sensor
);
  int cnt = 0;
  always @(posedge i_core_clk) begin
    if (i_go) cnt <= 1;
    else if (cnt != 0) cnt <= (cnt == 40) ? 0 : cnt + 1;
  end
  assign o_home = cnt inside {[1:6]};
  // the rotor never turns, so the sensor must be raised by hand
  assign o_home_sensor = cnt inside {[25:32]};
endmodule
`default_nettype wire

// ### bench/test_msim_core.sv
// bench for the simulation-mode core with master model
// assumes msim_pkg and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_msim_core;
  import msim_pkg::*;
  logic i_core_clk = 0, i_arst_n = 0, go = 0;
  logic [15:0] i_fw_version = FW_VER_400, i_user_wrap_rev = '0;
  logic [15:0] i_sensor_wrap_rev = '0, i_sensor_status = '0;
  logic [1:0] i_sim_mode = SIM_WRAP_1800, i_home_method = HOME_1SNS;
  logic [3:0] i_op_mode = '0, i_direct_mode = '0;
  logic [7:0] i_data_select_start_inputs = '0;
  logic [31:0] i_op_target = '0, i_direct_target = '0, i_preset_value = '0;
  logic i_sensor_priority = 1, i_user_wrap_en = 0, i_sensor_wrap_en = 0;
  logic i_io_param_invert = 1, i_motor_connected = 0, i_sensor_error = 1;
  logic i_start = 0, i_sequential_start_input = 0, i_stop = 0;
  logic i_forward_continuous_position_input = 0, i_forward_jog_input = 0;
  logic i_reverse_continuous_position_input = 0, i_reverse_jog_input = 0;
  logic i_forward_speed_control_input = 0, i_forward_fast_jog_input = 0;
  logic i_reverse_speed_control_input = 0, i_reverse_fast_jog_input = 0;
  logic i_forward_speed_push_input = 0, i_forward_inching_input = 0;
  logic i_reverse_speed_push_input = 0, i_reverse_inching_input = 0;
  logic i_forward_combined_jog_input = 0, i_reverse_combined_jog_input = 0;
  logic i_direct_valid = 0, i_fast_homing_input = 0, i_limit_sensor = 0;
  logic i_preset = 0, i_pulse_mode = 0, i_pulse = 0, i_pulse_dir = 0;
  logic i_free = 0, i_abs_valid_normal = 1, i_preset_set_normal = 1;
  logic i_factory_set_normal = 1;
  wire logic i_home, i_home_sensor;
  logic [31:0] o_command_pos, o_motor_pos, o_pos_deviation;
  logic [31:0] o_speed_deviation, o_overflow_rot;
  logic [15:0] o_calc_load, o_calc_torque, o_load_factor, o_motor_status;
  logic [15:0] o_wrap_rev;
  logic o_wrap_en, o_sim_active, o_busy, o_homing_refused, o_phys_excite;
  logic o_excitation_state_output, o_brake_release_output;
  logic o_phys_brake_release, o_absolute_position_valid_output;
  logic o_preset_home_set_output, o_factory_home_set_output;
  logic o_sensor_alarm, o_sensor_home_write;
  int bad_count = 0, checked = 0;
  msim_core uut (.*);
  msim_master u_master (.i_core_clk(i_core_clk), .i_go(go),
    .o_home(i_home), .o_home_sensor(i_home_sensor));
  initial begin
    forever #2.5 i_core_clk = ~i_core_clk;
  end
  task complete_run;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task do_reset(input logic [15:0] fw);
    i_arst_n <= 1'b0;
    i_fw_version <= fw;
    repeat (10) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_core_clk);
  endtask
  // pins go through two flops and an edge detector before being taken
  task wait_done;
    int n;
    n = 0;
    while (o_busy !== 1'b1 && n < 20) begin @(posedge i_core_clk); n++; end
    chk("busy", o_busy, 1);
    while (o_busy !== 1'b0 && n < 600) begin @(posedge i_core_clk); n++; end
    chk("done", n < 600, 1);
  endtask
  task t_stored(input logic [3:0] md, input logic [7:0] sel,
                input logic [31:0] tg, exp);
    i_op_mode <= md;
    i_op_target <= tg;
    if (sel == 0) i_start <= 1'b1;
    i_data_select_start_inputs <= sel;
    repeat (6) @(posedge i_core_clk);
    i_start <= 1'b0;
    i_data_select_start_inputs <= '0;
    wait_done();
    chk("command", o_command_pos, exp);
    chk("motor", o_motor_pos, exp);
  endtask
  task t_home;
    go <= 1'b1;
    @(posedge i_core_clk);
    go <= 1'b0;
    wait_done();
    chk("home pos", o_command_pos, 0);
  endtask
  task t_monitor(input logic new_fw);
    i_free <= 1'b1;
    repeat (5) @(posedge i_core_clk);
    chk("excite", o_excitation_state_output, 0);
    chk("valid", o_absolute_position_valid_output, new_fw);
    chk("preset set", o_preset_home_set_output, 0);
    chk("load", o_calc_load, UNDEF_VAL);
    chk("alarm", o_sensor_alarm, 0);
    chk("brake", o_brake_release_output, 0);
    chk("factory", o_factory_home_set_output, 0);
    chk("wrap", o_wrap_rev, WRAP_REV_1800);
    i_motor_connected <= 1'b1;
    i_sensor_wrap_rev <= 16'h0123;
    i_sensor_status <= 16'h0ABC;
    repeat (2) @(posedge i_core_clk);
    chk("sensor wrap", o_wrap_rev, 16'h0123);
    chk("status", o_motor_status, 16'h0ABC);
    i_motor_connected <= 1'b0;
    i_free <= 1'b0;
  endtask
  task t_motion;
    i_direct_mode <= OP_WRAP_ABS_PSH;
    i_direct_target <= 32'h8;
    i_direct_valid <= 1'b1;
    @(posedge i_core_clk);
    i_direct_valid <= 1'b0;
    wait_done();
    chk("direct", o_command_pos, 32'h8);
    i_reverse_jog_input <= 1'b1;
    repeat (20) @(posedge i_core_clk);
    i_reverse_jog_input <= 1'b0;
    wait_done();
    chk("jog sign", o_command_pos[31], 1'b1);
    i_fast_homing_input <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    i_fast_homing_input <= 1'b0;
    wait_done();
    chk("fast home", o_command_pos, 0);
    i_pulse_mode <= 1'b1;
    repeat (3) begin
      @(posedge i_core_clk) i_pulse <= 1'b1;
      repeat (2) @(posedge i_core_clk);
      i_pulse <= 1'b0;
      @(posedge i_core_clk);
    end
    repeat (5) @(posedge i_core_clk);
    chk("pulse", o_command_pos, 32'h3);
    i_pulse_mode <= 1'b0;
  endtask
  task t_old_fast;
    int n;
    do_reset(16'h0100);
    i_fast_homing_input <= 1'b1;
    n = 0;
    while (o_homing_refused !== 1'b1 && n < 20) begin
      @(posedge i_core_clk);
      n++;
    end
    chk("refused", o_homing_refused, 1);
    i_fast_homing_input <= 1'b0;
    t_monitor(1'b0);
  endtask
  initial begin
    do_reset(FW_VER_400);
    t_stored(OP_ABS_PSH, 8'h00, 32'h10, 32'h10);
    t_stored(OP_INC_CMD, 8'h80, 32'h5, 32'h15);
    t_home();
    t_motion();
    t_monitor(1'b1);
    t_old_fast();
    complete_run();
  end
  initial begin
    #100us;
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire

// ### rtl/msim_core.sv
// simulation-mode core of a stepping-motor driver: virtual motion,
// coordinates, monitors, forced outputs and alarm suppression
// assumes start/sensor/pulse pins asynchronous, config from same clock
`timescale 1ns/1ps
`default_nettype none
module msim_core
  import msim_pkg::*;
(
  // clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_arst_n,
  // configuration, same clock; sim mode, fw version and sensor priority read once at reset release
  input  wire logic [1:0]           i_sim_mode,
  input  wire logic [15:0]          i_fw_version,
  input  wire logic                 i_sensor_priority,
  input  wire logic [15:0]          i_user_wrap_rev,
  input  wire logic                 i_user_wrap_en,
  input  wire logic [15:0]          i_sensor_wrap_rev,
  input  wire logic                 i_sensor_wrap_en,
  input  wire logic                 i_io_param_invert,
  // motor and sensor
  input  wire logic                 i_motor_connected,
  input  wire logic [15:0]          i_sensor_status,
  input  wire logic                 i_sensor_error,
  // stored data
  input  wire logic                 i_start,
  input  wire logic                 i_sequential_start_input,
  input  wire logic [7:0]           i_data_select_start_inputs,
  input  wire logic [3:0]           i_op_mode,
  input  wire logic [POS_W-1:0]     i_op_target,
  // macro inputs
  input  wire logic                 i_forward_continuous_position_input,
  input  wire logic                 i_reverse_continuous_position_input,
  input  wire logic                 i_forward_speed_control_input,
  input  wire logic                 i_reverse_speed_control_input,
  input  wire logic                 i_forward_speed_push_input,
  input  wire logic                 i_reverse_speed_push_input,
  input  wire logic                 i_forward_jog_input,
  input  wire logic                 i_reverse_jog_input,
  input  wire logic                 i_forward_fast_jog_input,
  input  wire logic                 i_reverse_fast_jog_input,
  input  wire logic                 i_forward_inching_input,
  input  wire logic                 i_reverse_inching_input,
  input  wire logic                 i_forward_combined_jog_input,
  input  wire logic                 i_reverse_combined_jog_input,
  input  wire logic                 i_stop,
  // direct data from serial link decoder, same clock
  input  wire logic                 i_direct_valid,
  input  wire logic [3:0]           i_direct_mode,
  input  wire logic [POS_W-1:0]     i_direct_target,
  // homing
  input  wire logic                 i_home,
  input  wire logic                 i_fast_homing_input,
  input  wire logic [1:0]           i_home_method,
  input  wire logic                 i_home_sensor,
  input  wire logic                 i_limit_sensor,
  input  wire logic                 i_preset,
  input  wire logic [POS_W-1:0]     i_preset_value,
  // pulse input
  input  wire logic                 i_pulse_mode,
  input  wire logic                 i_pulse,
  input  wire logic                 i_pulse_dir,
  // free input, normal-time status
  input  wire logic                 i_free,
  input  wire logic                 i_abs_valid_normal,
  input  wire logic                 i_preset_set_normal,
  input  wire logic                 i_factory_set_normal,
  // coordinates and monitors
  output logic [POS_W-1:0]          o_command_pos,
  output logic [POS_W-1:0]          o_motor_pos,
  output logic [POS_W-1:0]          o_pos_deviation,
  output logic [POS_W-1:0]          o_speed_deviation,
  output logic [15:0]               o_calc_load,
  output logic [15:0]               o_calc_torque,
  output logic [POS_W-1:0]          o_overflow_rot,
  output logic [15:0]               o_load_factor,
  output logic [15:0]               o_motor_status,
  output logic [15:0]               o_wrap_rev,
  output logic                      o_wrap_en,
  output logic                      o_sim_active,
  output logic                      o_busy,
  output logic                      o_homing_refused,
  // signal-level outputs and physical drive
  output logic                      o_excitation_state_output,
  output logic                      o_brake_release_output,
  output logic                      o_phys_excite,
  output logic                      o_phys_brake_release,
  output logic                      o_absolute_position_valid_output,
  output logic                      o_preset_home_set_output,
  output logic                      o_factory_home_set_output,
  output logic                      o_sensor_alarm,
  output logic                      o_sensor_home_write
);

  // ----------------------------------------------------------------
  // pin synchronisers and start edges
  // ----------------------------------------------------------------
  localparam int NP = 32;
  logic [NP-1:0] pin_raw, pin_s, pin_rise;

  assign pin_raw = {i_start, i_sequential_start_input,
                    i_data_select_start_inputs,
                    i_forward_continuous_position_input,
                    i_reverse_continuous_position_input,
                    i_forward_speed_control_input,
                    i_reverse_speed_control_input,
                    i_forward_speed_push_input,
                    i_reverse_speed_push_input,
                    i_forward_jog_input, i_reverse_jog_input,
                    i_forward_fast_jog_input, i_reverse_fast_jog_input,
                    i_forward_inching_input, i_reverse_inching_input,
                    i_forward_combined_jog_input,
                    i_reverse_combined_jog_input,
                    i_stop, i_home, i_fast_homing_input,
                    i_home_sensor, i_limit_sensor, i_pulse,
                    i_pulse_dir, i_free};

  msim_sync #(.W(NP)) u_sync (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_async    (pin_raw),
    .o_sync     (pin_s)
  );

  msim_edge #(.W(NP)) u_edge (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_level    (pin_s),
    .o_rise     (pin_rise)
  );

  logic sd_go, mac_go, stop_s, home_go, fhome_go, hsns_s, lsns_s;
  logic pulse_rise, pdir_s, free_s, any_fw;
  assign sd_go      = |pin_rise[31:22];
  assign mac_go     = |pin_rise[21:8];
  assign any_fw     = |(pin_rise[21:8] & 14'h2AAA);
  assign stop_s     = pin_s[7];
  assign home_go    = pin_rise[6];
  assign fhome_go   = pin_rise[5];
  assign hsns_s     = pin_s[4];
  assign lsns_s     = pin_s[3];
  assign pulse_rise = pin_rise[2];
  assign pdir_s     = pin_s[1];
  assign free_s     = pin_s[0];

  // ----------------------------------------------------------------
  // mode latch: caught only after reset release (power cycle)
  // ----------------------------------------------------------------
  logic       cfg_done_reg;
  logic [1:0] mode_reg;
  logic       old_fw_reg, prio_reg;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_done_reg <= 1'b0;
      mode_reg     <= SIM_MODE_RST;
      old_fw_reg   <= 1'b0;
      prio_reg     <= 1'b0;
    end else if (!cfg_done_reg) begin
      cfg_done_reg <= 1'b1;
      mode_reg     <= i_sim_mode;
      old_fw_reg   <= (i_fw_version < FW_VER_400);
      prio_reg     <= i_sensor_priority;
    end
  end

  logic sim;
  assign sim = cfg_done_reg && (mode_reg != SIM_REAL);

  // old firmware treats mode 3 like mode 1
  logic [1:0] eff_mode;
  assign eff_mode = (old_fw_reg && mode_reg == SIM_WRAP_900) ?
                    SIM_NO_INFO : mode_reg;

  // ----------------------------------------------------------------
  // coordinate source
  // ----------------------------------------------------------------
  always_comb begin
    if (i_motor_connected && prio_reg) begin
      o_wrap_rev = i_sensor_wrap_rev;
      o_wrap_en  = i_sensor_wrap_en;
    end else if (i_motor_connected || !prio_reg ||
                 eff_mode == SIM_NO_INFO) begin
      o_wrap_rev = i_user_wrap_rev;
      o_wrap_en  = i_user_wrap_en;
    end else if (eff_mode == SIM_WRAP_1800) begin
      o_wrap_rev = WRAP_REV_1800;
      o_wrap_en  = 1'b1;
    end else begin
      o_wrap_rev = WRAP_REV_900;
      o_wrap_en  = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // motion state machine
  // ----------------------------------------------------------------
  msim_state_t  state_reg;
  logic [POS_W-1:0] cmd_reg, tgt_reg;
  logic             dir_reg, refused_reg;

  // push and speed variants collapse onto position control
  function automatic logic [3:0] map_mode(input logic [3:0] m);
    unique case (m)
      OP_WRAP_ABS_PSH:  map_mode = OP_WRAP_ABS;
      OP_WRAP_PROX_PSH: map_mode = OP_WRAP_PROX;
      OP_WRAP_FORWARD_SPEED_PUSH_INPUT:   map_mode = OP_WRAP_FW;
      OP_WRAP_REVERSE_SPEED_PUSH_INPUT:   map_mode = OP_WRAP_RV;
      OP_CONT_SPD, OP_CONT_PSH, OP_CONT_TRQ: map_mode = OP_CONT_POS;
      OP_ABS_PSH:       map_mode = OP_ABS;
      default:          map_mode = m;
    endcase
  endfunction

  logic       req_go;
  logic [3:0] req_mode;
  logic [POS_W-1:0] req_tgt;
  always_comb begin
    req_go   = sd_go | i_direct_valid;
    req_mode = map_mode(i_direct_valid ? i_direct_mode : i_op_mode);
    req_tgt  = i_direct_valid ? i_direct_target : i_op_target;
    if (req_mode == OP_INC_CMD || req_mode == OP_INC_FB) begin
      req_tgt = POS_W'(cmd_reg + req_tgt);
    end
  end

  logic fhome_ok;
  assign fhome_ok = !old_fw_reg || i_motor_connected;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg   <= MS_IDLE;
      cmd_reg     <= POS_RST;
      tgt_reg     <= POS_RST;
      dir_reg     <= 1'b0;
      refused_reg <= 1'b0;
    end else if (!sim) begin
      state_reg   <= MS_IDLE;
      refused_reg <= 1'b0;
    end else begin
      refused_reg <= 1'b0;
      unique case (state_reg)
        MS_IDLE: begin
          if (i_preset) begin
            cmd_reg <= i_preset_value;
          end else if (req_go) begin
            tgt_reg   <= req_tgt;
            dir_reg   <= (req_tgt < cmd_reg);
            state_reg <= (req_mode == OP_CONT_POS) ? MS_CONT : MS_MOVE;
          end else if (mac_go) begin
            dir_reg   <= !any_fw;
            state_reg <= MS_CONT;
          end else if (home_go && i_home_method != HOME_PUSH) begin
            dir_reg   <= 1'b1;
            state_reg <= MS_HOME;
          end else if (fhome_go) begin
            if (fhome_ok) begin
              state_reg <= MS_FHOME;
            end else begin
              refused_reg <= 1'b1;
            end
          end else if (i_pulse_mode) begin
            state_reg <= MS_PULSE;
          end
        end
        MS_MOVE: begin
          if (stop_s || cmd_reg == tgt_reg) begin
            state_reg <= MS_IDLE;
          end else begin
            cmd_reg <= dir_reg ? cmd_reg - 1'b1 : cmd_reg + 1'b1;
          end
        end
        MS_CONT: begin
          if (stop_s || ~|pin_s[21:8] & ~|pin_s[31:22]) begin
            state_reg <= MS_IDLE;
          end else begin
            cmd_reg <= dir_reg ? cmd_reg - 1'b1 : cmd_reg + 1'b1;
          end
        end
        MS_HOME: begin
          // sensors never fire by themselves; master drives them
          if (stop_s) begin
            state_reg <= MS_IDLE;
          end else if (hsns_s) begin
            cmd_reg   <= POS_RST;
            state_reg <= MS_IDLE;
          end else if (lsns_s && i_home_method != HOME_1SNS) begin
            dir_reg <= ~dir_reg;
          end else begin
            cmd_reg <= dir_reg ? cmd_reg - 1'b1 : cmd_reg + 1'b1;
          end
        end
        MS_FHOME: begin
          if (stop_s || cmd_reg == POS_RST) begin
            state_reg <= MS_IDLE;
          end else begin
            cmd_reg <= cmd_reg[POS_W-1] ? cmd_reg + 1'b1
                                        : cmd_reg - 1'b1;
          end
        end
        MS_PULSE: begin
          if (!i_pulse_mode) begin
            state_reg <= MS_IDLE;
          end else if (pulse_rise) begin
            cmd_reg <= pdir_s ? cmd_reg - 1'b1 : cmd_reg + 1'b1;
          end
        end
        default: state_reg <= MS_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // monitors (registered); command position and status flags taken straight from the state
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_motor_pos       <= POS_RST;
      o_motor_status    <= 16'h0000;
      o_pos_deviation   <= ZERO_VALUE;
      o_speed_deviation <= ZERO_VALUE;
      o_overflow_rot    <= ZERO_VALUE;
      o_load_factor     <= 16'h0000;
      o_calc_load       <= UNDEF_VAL;
      o_calc_torque     <= UNDEF_VAL;
    end else begin
      o_motor_pos       <= cmd_reg;
      o_motor_status    <= i_sensor_status;
      o_pos_deviation   <= ZERO_VALUE;
      o_speed_deviation <= ZERO_VALUE;
      o_overflow_rot    <= ZERO_VALUE;
      o_load_factor     <= 16'h0000;
      o_calc_load       <= UNDEF_VAL;
      o_calc_torque     <= UNDEF_VAL;
    end
  end

  assign o_command_pos    = cmd_reg;
  assign o_sim_active     = sim;
  assign o_busy           = (state_reg != MS_IDLE);
  assign o_homing_refused = refused_reg;

  // ----------------------------------------------------------------
  // signal outputs; I/O config parameters are not applied in sim
  // ----------------------------------------------------------------
  logic io_inv;
  assign io_inv = i_io_param_invert & ~sim;

  logic abs_v, pre_v, fac_v;
  always_comb begin
    if (!old_fw_reg) begin
      abs_v = 1'b1;
      pre_v = 1'b0;
      fac_v = 1'b0;
    end else if (!i_motor_connected) begin
      abs_v = 1'b0;
      pre_v = 1'b0;
      fac_v = 1'b0;
    end else begin
      abs_v = i_abs_valid_normal;
      pre_v = i_preset_set_normal;
      fac_v = i_factory_set_normal;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_excitation_state_output        <= 1'b0;
      o_brake_release_output           <= 1'b0;
      o_phys_excite                    <= 1'b0;
      o_phys_brake_release             <= 1'b0;
      o_absolute_position_valid_output <= 1'b0;
      o_preset_home_set_output         <= 1'b0;
      o_factory_home_set_output        <= 1'b0;
      o_sensor_alarm                   <= 1'b0;
      o_sensor_home_write              <= 1'b0;
    end else begin
      // signal level still follows the free input
      // io_inv is zero in sim, so no parameter can flip these levels
      o_excitation_state_output <= (sim & ~free_s) ^ io_inv;
      o_brake_release_output    <= (sim & ~free_s) ^ io_inv;
      o_phys_excite             <= 1'b0;
      o_phys_brake_release      <= 1'b0;
      o_absolute_position_valid_output <= sim ? abs_v
                                              : i_abs_valid_normal;
      o_preset_home_set_output  <= sim ? pre_v : i_preset_set_normal;
      o_factory_home_set_output <= sim ? fac_v : i_factory_set_normal;
      o_sensor_alarm            <= cfg_done_reg & ~sim
                                   & i_sensor_error;
      o_sensor_home_write       <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### rtl/msim_edge.sv
// rising-edge detector on already synchronised levels
// assumes inputs are on i_core_clk
`timescale 1ns/1ps
`default_nettype none
module msim_edge #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_arst_n,
  // levels in, pulses out
  input  wire logic [W-1:0] i_level,
  output logic      [W-1:0] o_rise
);
  logic [W-1:0] last_reg;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      last_reg <= '0;
    end else begin
      last_reg <= i_level;
    end
  end

  assign o_rise = i_level & ~last_reg;
endmodule
`default_nettype wire

// ### rtl/msim_pkg.sv
// constants and types for the motor driver simulation-mode block
// assumes one core clock domain and no register bus
package msim_pkg;

  // ----------------------------------------------------------------
  // simulation-mode setting
  // ----------------------------------------------------------------
  localparam logic [1:0] SIM_REAL      = 2'h0;
  localparam logic [1:0] SIM_NO_INFO   = 2'h1;
  localparam logic [1:0] SIM_WRAP_1800 = 2'h2;
  localparam logic [1:0] SIM_WRAP_900  = 2'h3;
  localparam logic [1:0] SIM_MODE_RST  = 2'h0;

  // ----------------------------------------------------------------
  // wrap ranges in revolutions for the fixed virtual settings
  // ----------------------------------------------------------------
  localparam logic [15:0] WRAP_REV_1800 = 16'h0708;
  localparam logic [15:0] WRAP_REV_900  = 16'h0384;

  // ----------------------------------------------------------------
  // firmware version, fixed point x100 (4.00)
  // ----------------------------------------------------------------
  localparam logic [15:0] FW_VER_400 = 16'h0190;

  // ----------------------------------------------------------------
  // coordinate, widths and reset values
  // ----------------------------------------------------------------
  localparam int          POS_W      = 32;
  localparam logic [31:0] POS_RST    = 32'h0000_0000;
  localparam logic [31:0] ZERO_VALUE = 32'h0000_0000;
  localparam logic [15:0] UNDEF_VAL  = 16'hFFFF;

  // ----------------------------------------------------------------
  // stored operation modes
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_ABS       = 4'h0;
  localparam logic [3:0] OP_INC_CMD   = 4'h1;
  localparam logic [3:0] OP_INC_FB    = 4'h2;
  localparam logic [3:0] OP_CONT_POS  = 4'h3;
  localparam logic [3:0] OP_WRAP_ABS  = 4'h4;
  localparam logic [3:0] OP_WRAP_PROX = 4'h5;
  localparam logic [3:0] OP_WRAP_FW   = 4'h6;
  localparam logic [3:0] OP_WRAP_RV   = 4'h7;
  localparam logic [3:0] OP_WRAP_ABS_PSH  = 4'h8;
  localparam logic [3:0] OP_WRAP_PROX_PSH = 4'h9;
  localparam logic [3:0] OP_WRAP_FORWARD_SPEED_PUSH_INPUT   = 4'hA;
  localparam logic [3:0] OP_WRAP_REVERSE_SPEED_PUSH_INPUT   = 4'hB;
  localparam logic [3:0] OP_CONT_SPD  = 4'hC;
  localparam logic [3:0] OP_CONT_PSH  = 4'hD;
  localparam logic [3:0] OP_CONT_TRQ  = 4'hE;
  localparam logic [3:0] OP_ABS_PSH   = 4'hF;

  // ----------------------------------------------------------------
  // homing methods and motion kinds
  // ----------------------------------------------------------------
  localparam logic [1:0] HOME_3SNS = 2'h0;
  localparam logic [1:0] HOME_2SNS = 2'h1;
  localparam logic [1:0] HOME_1SNS = 2'h2;
  localparam logic [1:0] HOME_PUSH = 2'h3;

  typedef enum logic [2:0] {
    MS_IDLE  = 3'b000,
    MS_MOVE  = 3'b001,
    MS_CONT  = 3'b011,
    MS_HOME  = 3'b010,
    MS_FHOME = 3'b110,
    MS_PULSE = 3'b111
  } msim_state_t;

endpackage

// ### rtl/msim_sync.sv
// two-flop synchroniser for a bus of pin inputs
// assumes the inputs are asynchronous to i_core_clk
`timescale 1ns/1ps
`default_nettype none
module msim_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_arst_n,
  // data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_reg <= '0;
      o_sync   <= '0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule
`default_nettype wire
